// ---- spectral_gain_agc_config.sv ----
// Spectral gain, AGC threshold and flicker persistence configuration with an AHB-Lite slave.
// Assumes samples and flicker results come from logic on the same clock; no synchronisers.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps

// Functional notes
// [RULE1] Five-bit gain code, values 0..10 give 0.5x doubling to 512x; reset 9.
// [RULE2] With AGC on, gain drops when data reaches high threshold; codes 50..87.5%, reset 3.
// [RULE3] With AGC on, gain rises when data falls to low threshold; codes 12.5..50%, reset 3.
// [RULE4] Thresholds are fractions of full scale = (step count + 1) * (step size + 1).
// [RULE5] Flicker status and interrupt change after 2^(setting-1) differing results; reset 2.
// [RULE6] Automatic gain control acts only while its enable bit is set; enable resets low.
// [RULE7] Automatic raises never exceed the four-bit maximum gain code, which resets to 9.
// [RULE8] Gain holds between thresholds, moves one step per adjustment, stays in 0..10.
module spectral_gain_agc_config (
  input  wire logic                                clock_i,
  input  wire logic                                reset_n_i,
  input  wire logic                                hsel_i,
  input  wire logic [agc_cfg_pkg::ADDR_W-1:0]      haddr_i,
  input  wire logic [1:0]                          htrans_i,
  input  wire logic                                hwrite_i,
  input  wire logic [2:0]                          hsize_i,
  input  wire logic [31:0]                         hwdata_i,
  input  wire logic                                hready_i,
  output logic                                     hreadyout_o,
  output logic                                     hresp_o,
  output logic [31:0]                              hrdata_o,
  input  wire agc_cfg_pkg::sample_t                sample_i,
  input  wire agc_cfg_pkg::flicker_t               flicker_i,
  output logic [agc_cfg_pkg::GAIN_W-1:0]           spectral_gain_code_o,
  output logic                                     flicker_status_o,
  output logic                                     system_interrupt_o
);
  import agc_cfg_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bus_state_t               bus_state;
  logic [ADDR_W-1:0]        addr_q;
  logic                     accept;
  logic                     wr_en;
  logic [31:0]              read_word;
  logic [GAIN_W-1:0]        gain_code;
  logic [THR_W-1:0]         gain_reduce_threshold;
  logic [THR_W-1:0]         gain_raise_threshold;
  logic [PERS_W-1:0]        flicker_persistence;
  logic                     spectral_autogain_enable;
  logic [AGMAX_W-1:0]       autogain_max_code;
  logic [STEPS_W-1:0]       integration_step_count;
  logic [SSIZE_W-1:0]       integration_step_size;
  logic [IRQ_W-1:0]         irq_status;
  logic [IRQ_W-1:0]         irq_enable;
  logic [IRQ_W-1:0]         irq_set;
  logic [IRQ_W-1:0]         irq_clear;
  logic [FS_W-1:0]          full_scale;
  logic [FS_W+2:0]          high_product;
  logic [FS_W+2:0]          low_product;
  logic [FS_W-1:0]          high_level;
  logic [FS_W-1:0]          low_level;
  logic [FS_W-1:0]          data_ext;
  logic                     at_high;
  logic                     at_low;
  logic [GAIN_W-1:0]        eff_max;
  logic                     agc_down;
  logic                     agc_up;
  logic                     wr_gain;
  logic                     flicker_changed;
  logic                     flicker_status;

  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    hits = (addr == (ADDR_W'(idx) << IDX_LSB));
  endfunction

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // ****************************************************************
  // AHB-Lite slave: writes with no wait, reads with one wait state
  // ****************************************************************
  // The read wait lets a write in the preceding data phase land first
  assign accept      = hsel_i && (htrans_i == HTRANS_NONSEQ) && hready_i;
  assign hreadyout_o = (bus_state != BUS_READ_WAIT);
  assign hresp_o     = 1'b0;
  assign wr_en       = (bus_state == BUS_WRITE);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_state <= BUS_IDLE;
      addr_q    <= '0;
    end else begin
      unique case (bus_state)
        BUS_READ_WAIT: bus_state <= BUS_READ_DONE;
        BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
          if (accept) begin
            bus_state <= hwrite_i ? BUS_WRITE : BUS_READ_WAIT;
            addr_q    <= haddr_i;
          end else begin
            bus_state <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    read_word = '0;
    if (hits(addr_q, IDX_GAIN_CFG)) begin
      read_word[GAIN_LSB +: GAIN_W] = gain_code;
    end else if (hits(addr_q, IDX_HYST_CFG)) begin
      read_word[HIGH_LSB +: THR_W]  = gain_reduce_threshold;
      read_word[LOW_LSB +: THR_W]   = gain_raise_threshold;
      read_word[PERS_LSB +: PERS_W] = flicker_persistence;
    end else if (hits(addr_q, IDX_AUTOGAIN)) begin
      read_word[AGMAX_LSB +: AGMAX_W] = autogain_max_code;
      read_word[AGEN_BIT]             = spectral_autogain_enable;
    end else if (hits(addr_q, IDX_INTEG)) begin
      read_word[STEPS_LSB +: STEPS_W] = integration_step_count;
      read_word[SSIZE_LSB +: SSIZE_W] = integration_step_size;
    end else if (hits(addr_q, IDX_IRQ_STATUS)) begin
      read_word[IRQ_GAIN +: IRQ_W] = irq_status;
      read_word[FLICK_LIVE]        = flicker_status;
    end else if (hits(addr_q, IDX_IRQ_ENABLE)) begin
      read_word[IRQ_GAIN +: IRQ_W] = irq_enable;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_o <= '0;
    end else if (bus_state == BUS_READ_WAIT) begin
      hrdata_o <= read_word;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_reduce_threshold <= HIGH_RST; // [RULE2]
      gain_raise_threshold  <= LOW_RST; // [RULE3]
      flicker_persistence   <= PERS_RST; // [RULE5]
    end else if (wr_en && hits(addr_q, IDX_HYST_CFG)) begin
      gain_reduce_threshold <= hwdata_i[HIGH_LSB +: THR_W];
      gain_raise_threshold  <= hwdata_i[LOW_LSB +: THR_W];
      flicker_persistence   <= hwdata_i[PERS_LSB +: PERS_W];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spectral_autogain_enable <= 1'b0; // [RULE6]
      autogain_max_code        <= AGMAX_RST; // [RULE7]
    end else if (wr_en && hits(addr_q, IDX_AUTOGAIN)) begin
      spectral_autogain_enable <= hwdata_i[AGEN_BIT];
      autogain_max_code        <= hwdata_i[AGMAX_LSB +: AGMAX_W];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      integration_step_count <= '0;
      integration_step_size  <= '0;
    end else if (wr_en && hits(addr_q, IDX_INTEG)) begin
      integration_step_count <= hwdata_i[STEPS_LSB +: STEPS_W];
      integration_step_size  <= hwdata_i[SSIZE_LSB +: SSIZE_W];
    end
  end

  // ****************************************************************
  // Thresholds as eighths of full scale
  // ****************************************************************
  always_comb begin
    full_scale   = FS_W'((STEPS_W + 1)'(integration_step_count) + 1'b1)
                 * FS_W'((SSIZE_W + 1)'(integration_step_size) + 1'b1); // [RULE4]
    high_product = (FS_W + 3)'(full_scale) * (FS_W + 3)'(HIGH_EIGHTHS + 3'(gain_reduce_threshold));
    low_product  = (FS_W + 3)'(full_scale) * (FS_W + 3)'(LOW_EIGHTHS + 3'(gain_raise_threshold));
    high_level   = high_product[EIGHTHS_SH +: FS_W]; // [RULE2]
    low_level    = low_product[EIGHTHS_SH +: FS_W]; // [RULE3]
    data_ext     = FS_W'(sample_i.count);
  end

  // ****************************************************************
  // Automatic gain control
  // ****************************************************************
  // High wins when both thresholds meet, so saturation is resolved first
  always_comb begin
    at_high  = (data_ext >= high_level);
    at_low   = (data_ext <= low_level);
    eff_max  = (GAIN_W'(autogain_max_code) > GAIN_TOP) ? GAIN_TOP : GAIN_W'(autogain_max_code);
    agc_down = spectral_autogain_enable && sample_i.valid && at_high && (gain_code != '0); // [RULE2]
    agc_up   = spectral_autogain_enable && sample_i.valid && !at_high && at_low
             && (gain_code < eff_max); // [RULE3]
    wr_gain  = wr_en && hits(addr_q, IDX_GAIN_CFG);
  end

  // A software write in the same cycle as an AGC step takes precedence
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_code <= GAIN_RST; // [RULE1]
    end else if (wr_gain) begin
      gain_code <= (hwdata_i[GAIN_LSB +: GAIN_W] > GAIN_TOP) ? GAIN_TOP
                 : hwdata_i[GAIN_LSB +: GAIN_W]; // [RULE8]
    end else if (agc_down) begin
      gain_code <= gain_code - 5'h01; // [RULE8]
    end else if (agc_up) begin
      gain_code <= gain_code + 5'h01; // [RULE7]
    end
  end

  assign spectral_gain_code_o = gain_code;

  // ****************************************************************
  // Flicker persistence and interrupts
  // ****************************************************************
  flicker_persistence_filter u_flicker (
    .clock_i       (clock_i),
    .reset_n_i     (reset_n_i),
    .flicker_i     (flicker_i),
    .persistence_i (flicker_persistence),
    .status_o      (flicker_status),
    .changed_o     (flicker_changed)
  );

  assign flicker_status_o = flicker_status;

  always_comb begin
    irq_set            = '0;
    irq_set[IRQ_GAIN]  = agc_down || agc_up;
    irq_set[IRQ_FLICK] = flicker_changed; // [RULE5]
    irq_clear          = (wr_en && hits(addr_q, IDX_IRQ_CLEAR)) ? hwdata_i[IRQ_GAIN +: IRQ_W] : '0;
  end

  // Set beats clear so no event is lost in the clearing cycle
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_set;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_enable <= '0;
    end else if (wr_en && hits(addr_q, IDX_IRQ_ENABLE)) begin
      irq_enable <= hwdata_i[IRQ_GAIN +: IRQ_W];
    end
  end

  assign system_interrupt_o = |(irq_status & irq_enable);

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_GAIN_IN_RANGE: assert property (gain_code <= GAIN_TOP) // [RULE1]
    else $error("gain code outside 0 to 10");

  AST_REDUCE_ON_HIGH: assert property ( // [RULE2]
    agc_down && !wr_gain |=> gain_code == $past(gain_code) - 5'h01)
    else $error("gain not reduced one step at high threshold");

  AST_RAISE_ON_LOW: assert property ( // [RULE3]
    spectral_autogain_enable && sample_i.valid && at_low && !at_high && gain_code < eff_max
    && !wr_gain |=> gain_code == $past(gain_code) + 5'h01)
    else $error("gain not raised one step at low threshold");

  AST_LEVELS_ORDERED: assert property ( // [RULE4]
    high_level >= low_level && high_level <= full_scale)
    else $error("threshold levels out of order against full scale");

  AST_FLICKER_IRQ_FOLLOWS: assert property (flicker_changed |=> irq_status[IRQ_FLICK]) // [RULE5]
    else $error("flicker change did not set its status bit");

  AST_OFF_HOLDS_GAIN: assert property ( // [RULE6]
    !spectral_autogain_enable && !wr_gain |=> $stable(gain_code))
    else $error("gain moved while automatic control is off");

  // The limit is the one in force when the step was taken, not a later write
  AST_RAISE_BELOW_MAX: assert property ( // [RULE7]
    !wr_gain && !agc_down ##1 gain_code > $past(gain_code) |-> gain_code <= $past(eff_max))
    else $error("automatic raise passed the maximum code");

  AST_BETWEEN_HOLDS: assert property ( // [RULE8]
    sample_i.valid && !at_high && !at_low && !wr_gain |=> $stable(gain_code))
    else $error("gain changed between thresholds");

  AST_STEP_SETS_STATUS: assert property ( // [RULE8]
    agc_down || agc_up |=> irq_status[IRQ_GAIN])
    else $error("gain step did not set its status bit");

  // Gain may move only on a sample or a software write
  AST_HOLD_NO_SAMPLE: assert property ( // [RULE8]
    !sample_i.valid && !wr_gain |=> $stable(gain_code))
    else $error("gain moved without a sample");

  AST_ONE_STEP: assert property ( // [RULE8]
    !wr_gain |=> gain_code == $past(gain_code) || gain_code == $past(gain_code) + 5'h01
    || gain_code == $past(gain_code) - 5'h01)
    else $error("gain moved more than one step");

  COV_GAIN_DOWN: cover property (agc_down ##1 system_interrupt_o);
  COV_GAIN_UP: cover property (agc_up ##[1:3] agc_up);
  COV_READ_AFTER_WRITE: cover property (wr_gain ##[1:2] bus_state == BUS_READ_WAIT);

endmodule

// ---- agc_cfg_pkg.sv ----
// Constants, field layout and carrier types of the spectral gain and AGC configuration block.
// Assumes a 20 MHz core clock and a single AHB-Lite master with word accesses.
package agc_cfg_pkg;

  // ****************************************************************
  // Bus and register map (byte address = four times the index)
  // ****************************************************************
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned IDX_W          = 8;
  localparam int unsigned IDX_LSB        = 2;
  localparam logic [7:0]  IDX_GAIN_CFG   = 8'haa;
  localparam logic [7:0]  IDX_HYST_CFG   = 8'hb3;
  localparam logic [7:0]  IDX_AUTOGAIN   = 8'hc0;
  localparam logic [7:0]  IDX_INTEG      = 8'hc1;
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'hc2;
  localparam logic [7:0]  IDX_IRQ_ENABLE = 8'hc3;
  localparam logic [7:0]  IDX_IRQ_CLEAR  = 8'hc4;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned GAIN_LSB   = 0;
  localparam int unsigned GAIN_W     = 5;
  localparam int unsigned HIGH_LSB   = 6;
  localparam int unsigned LOW_LSB    = 4;
  localparam int unsigned THR_W      = 2;
  localparam int unsigned PERS_LSB   = 0;
  localparam int unsigned PERS_W     = 3;
  localparam int unsigned AGMAX_LSB  = 0;
  localparam int unsigned AGMAX_W    = 4;
  localparam int unsigned AGEN_BIT   = 4;
  localparam int unsigned STEPS_LSB  = 0;
  localparam int unsigned STEPS_W    = 8;
  localparam int unsigned SSIZE_LSB  = 8;
  localparam int unsigned SSIZE_W    = 16;
  localparam int unsigned IRQ_W      = 2;
  localparam int unsigned IRQ_GAIN   = 0;
  localparam int unsigned IRQ_FLICK  = 1;
  localparam int unsigned FLICK_LIVE = 8;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [4:0] GAIN_RST      = 5'h09;
  localparam logic [4:0] GAIN_TOP      = 5'h0a;
  localparam logic [1:0] HIGH_RST      = 2'h3;
  localparam logic [1:0] LOW_RST       = 2'h3;
  localparam logic [2:0] PERS_RST      = 3'h2;
  localparam logic [3:0] AGMAX_RST     = 4'h9;
  localparam logic [2:0] HIGH_EIGHTHS  = 3'h4;
  localparam logic [2:0] LOW_EIGHTHS   = 3'h1;
  localparam int unsigned EIGHTHS_SH   = 3;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned FS_W         = STEPS_W + SSIZE_W + 2;
  localparam int unsigned PERS_CNT_W   = 7;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] count;
  } sample_t;

  typedef struct packed {
    logic valid;
    logic result;
  } flicker_t;

  typedef enum logic [1:0] {
    BUS_IDLE      = 2'b00,
    BUS_WRITE     = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } bus_state_t;

endpackage

// ---- flicker_persistence_filter.sv ----
// Persistence filter for the flicker detect status.
// Assumes flicker results arrive on the core clock, one valid pulse per result.
`timescale 1ns/10ps

module flicker_persistence_filter (
  input  wire logic                              clock_i,
  input  wire logic                              reset_n_i,
  input  wire agc_cfg_pkg::flicker_t             flicker_i,
  input  wire logic [agc_cfg_pkg::PERS_W-1:0]    persistence_i,
  output logic                                   status_o,
  output logic                                   changed_o
);
  import agc_cfg_pkg::*;

  logic [PERS_CNT_W-1:0] diff_count;
  logic [PERS_CNT_W-1:0] need;
  logic [PERS_CNT_W-1:0] next_count;

  // Setting zero would mean half a result; treat it as one
  always_comb begin
    need = (persistence_i == '0) ? PERS_CNT_W'(1) : PERS_CNT_W'(1) << (persistence_i - 3'h1);
    next_count = diff_count + PERS_CNT_W'(1);
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      diff_count <= '0;
      status_o   <= 1'b0;
      changed_o  <= 1'b0;
    end else begin
      changed_o <= 1'b0;
      if (flicker_i.valid) begin
        if (flicker_i.result == status_o) begin
          diff_count <= '0;
        end else if (next_count >= need) begin
          diff_count <= '0;
          status_o   <= flicker_i.result; // [RULE5]
          changed_o  <= 1'b1; // [RULE5]
        end else begin
          diff_count <= next_count;
        end
      end
    end
  end

  AST_PERS_CHANGE_NEEDS_RUN: assert property ( // [RULE5]
    @(posedge clock_i) disable iff (!reset_n_i)
    (status_o != $past(status_o)) |-> ($past(next_count) >= $past(need)))
    else $error("flicker status changed before the persistence count was met");

  AST_PERS_PULSE_WITH_CHANGE: assert property ( // [RULE5]
    @(posedge clock_i) disable iff (!reset_n_i)
    changed_o |-> (status_o != $past(status_o)))
    else $error("flicker change pulse without a status change");

  COV_PERS_CHANGE: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    flicker_i.valid ##1 changed_o);

endmodule

// ---- test_spectral_gain_agc_config.sv ----
// Self-checking bench for the spectral gain, AGC threshold and flicker persistence block.
// Assumes one bench AHB-Lite master, hreadyout looped back to hready, samples on the core clock.
`timescale 1ns/10ps

module test_spectral_gain_agc_config;
  import agc_cfg_pkg::*;

  logic              clock_i   = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              hsel      = 1'b0;
  logic [ADDR_W-1:0] haddr     = '0;
  logic [1:0]        htrans    = 2'h0;
  logic              hwrite    = 1'b0;
  logic [31:0]       hwdata    = 32'h0;
  logic              hreadyout;
  logic [31:0]       hrdata;
  logic              hresp;
  sample_t           sample    = '0;
  flicker_t          flicker   = '0;
  logic [GAIN_W-1:0] gain;
  logic              fstat;
  logic              irq;
  logic [31:0]       rd;
  logic [7:0]        idx_list [8] = '{IDX_GAIN_CFG, IDX_HYST_CFG, IDX_AUTOGAIN, IDX_INTEG,
                                      IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR, 8'hfc};
  int                errors    = 0;
  int                tests_run = 0;
  int unsigned       seed      = 51304;
  int                n;
  // Reference model state, reset values
  int mg = 9, mmax = 9, men = 0, mh = 3, ml = 3, mp = 2;
  int msc = 0, mss = 0, mirq = 0, mie = 0, mfs = 0, mrun = 0;

  spectral_gain_agc_config dut (
    .clock_i              (clock_i),
    .reset_n_i            (reset_n_i),
    .hsel_i               (hsel),
    .haddr_i              (haddr),
    .htrans_i             (htrans),
    .hwrite_i             (hwrite),
    .hsize_i              (3'h2),
    .hwdata_i             (hwdata),
    .hready_i             (hreadyout),
    .hreadyout_o          (hreadyout),
    .hresp_o              (hresp),
    .hrdata_o             (hrdata),
    .sample_i             (sample),
    .flicker_i            (flicker),
    .spectral_gain_code_o (gain),
    .flicker_status_o     (fstat),
    .system_interrupt_o   (irq)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] mrd(input logic [7:0] idx);
    case (idx)
      IDX_GAIN_CFG:   return 32'(mg);
      IDX_HYST_CFG:   return 32'(mh * 64 + ml * 16 + mp);
      IDX_AUTOGAIN:   return 32'(men * 16 + mmax);
      IDX_INTEG:      return 32'(mss * 256 + msc);
      IDX_IRQ_STATUS: return 32'(mirq + mfs * 256);
      IDX_IRQ_ENABLE: return 32'(mie);
      default:        return 32'h0;
    endcase
  endfunction

  task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds each phase until hready is sampled high; read data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= ADDR_W'({idx, 2'b00});
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
    case (idx)
      IDX_GAIN_CFG:   mg = (d[4:0] > 10) ? 10 : int'(d[4:0]);
      IDX_HYST_CFG: begin
        mh = int'(d[7:6]);
        ml = int'(d[5:4]);
        mp = int'(d[2:0]);
      end
      IDX_AUTOGAIN: begin
        mmax = int'(d[3:0]);
        men  = int'(d[4]);
      end
      IDX_INTEG: begin
        msc = int'(d[7:0]);
        mss = int'(d[23:8]);
      end
      IDX_IRQ_ENABLE: mie = int'(d[1:0]);
      IDX_IRQ_CLEAR:  mirq &= ~int'(d[1:0]);
      default: ;
    endcase
  endtask

  task automatic rdck(input logic [7:0] idx);
    bus(1'b0, idx, 32'h0);
    cmp($sformatf("register %h", idx), rd, mrd(idx));
    cmp("response", 32'(hresp), 32'h0);
  endtask

  // Two edges let the flicker interrupt bit land before the outputs are compared
  task automatic settle();
    @(posedge clock_i);
    @(posedge clock_i);
    cmp("gain code", 32'(gain), 32'(mg));
    cmp("flicker status", 32'(fstat), 32'(mfs));
    cmp("interrupt", 32'(irq), 32'((mirq & mie) != 0));
  endtask

  task automatic put_sample(input int c);
    int fs;
    int hi;
    int lo;
    int top;
    fs  = (msc + 1) * (mss + 1);
    hi  = fs * (4 + mh) / 8;
    lo  = fs * (1 + ml) / 8;
    top = (mmax > 10) ? 10 : mmax;
    sample <= '{valid: 1'b1, count: DATA_W'(c)};
    @(posedge clock_i);
    sample <= '{valid: 1'b0, count: DATA_W'(c)};
    // Data at the high level never raises, even when the gain is already at zero
    if (men != 0 && c >= hi && mg > 0) begin
      mg--;
      mirq |= 1;
    end else if (men != 0 && c < hi && c <= lo && mg < top) begin
      mg++;
      mirq |= 1;
    end
    settle();
  endtask

  task automatic put_flicker(input logic r);
    n = (mp == 0) ? 1 : 1 << (mp - 1);
    flicker <= '{valid: 1'b1, result: r};
    @(posedge clock_i);
    flicker <= '{valid: 1'b0, result: r};
    mrun = (int'(r) == mfs) ? 0 : mrun + 1;
    if (mrun == n) begin
      mfs ^= 1;
      mrun = 0;
      mirq |= 2;
    end
    settle();
  endtask

  task automatic complete_run();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    forever #25 clock_i = ~clock_i;
  end

  // Whole sequence needs under a thousand cycles; the 40000-cycle limit leaves ample margin
  initial begin
    #(50 * 40000);
    errors++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    cmp("reset gain", 32'(gain), 32'(GAIN_RST));
    foreach (idx_list[i]) rdck(idx_list[i]);
    wr(IDX_GAIN_CFG, 32'h1f);
    rdck(IDX_GAIN_CFG);
    wr(IDX_GAIN_CFG, 32'h0);
    wr(IDX_IRQ_ENABLE, 32'h3);
    put_sample(0);
    wr(IDX_INTEG, 32'h0207);
    wr(IDX_AUTOGAIN, 32'h13);
    repeat (5) put_sample(0);
    wr(IDX_IRQ_CLEAR, 32'h1);
    settle();
    put_sample(30);
    wr(IDX_IRQ_ENABLE, 32'h2);
    settle();
    rdck(IDX_IRQ_STATUS);
    wr(IDX_IRQ_ENABLE, 32'h3);
    for (int i = 0; i < 80; i++) begin
      if (i % 8 == 0) begin
        wr(IDX_HYST_CFG, rnd() & 32'hff);
        wr(IDX_AUTOGAIN, 32'h10 | (rnd() % 12));
        wr(IDX_IRQ_CLEAR, rnd() & 32'h3);
        wr(IDX_GAIN_CFG, rnd() & 32'h1f);
        rdck(IDX_HYST_CFG);
        rdck(IDX_IRQ_STATUS);
      end
      put_sample(int'(rnd() % 28));
    end
    // Settings 0 to 3: a run of n-1 cut short by an equal result, then a full run that flips
    for (int p = 0; p < 4; p++) begin
      wr(IDX_HYST_CFG, 32'(p));
      n = (p == 0) ? 1 : 1 << (p - 1);
      repeat (n - 1) put_flicker(mfs == 0);
      put_flicker(mfs != 0);
      repeat (n) put_flicker(mfs == 0);
      rdck(IDX_IRQ_STATUS);
    end
    foreach (idx_list[i]) rdck(idx_list[i]);
    wr(IDX_IRQ_CLEAR, 32'h3);
    settle();
    complete_run();
  end
endmodule
